//--- src/isr_pkg.sv
package isr_pkg;
   // target address and pointer layout
   localparam logic [6:0] ISR_DEF_ADDR = 7'h0a;
   localparam int ISR_PTR_W = 8;
   localparam int ISR_BYTES_PER_REG = 4;
   localparam logic [ISR_PTR_W-1:0] ISR_PTR_RST = 8'h00;
   localparam logic [2:0] ISR_BIT_MSB = 3'h7;
   localparam logic [1:0] ISR_BYTE_LAST = 2'h3;
   localparam logic [1:0] ISR_BYTE_SIDE = 2'h2;

   // host-side register access carried as one bundle
   typedef struct packed {
      logic [ISR_PTR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd_capture;
      logic rd_commit;
   } isr_req_t;

   // bus phase of the target engine
   typedef enum logic [6:0] {
      ISR_IDLE = 7'b0000001,
      ISR_CTRL = 7'b0000010,
      ISR_CACK = 7'b0000100,
      ISR_RXB = 7'b0001000,
      ISR_RACK = 7'b0010000,
      ISR_TXB = 7'b0100000,
      ISR_TACK = 7'b1000000
   } isr_state_t;
endpackage

//--- src/isr_target.sv
`timescale 1ns/10ps
// Contract
// [R1] default target address 0001010b, most significant bit first on the wire
// [R2] override strap selects the address strap value as target address
// [R3] ack matching control byte; mismatch ignores bus until next start
// [R4] after write control byte, ack address byte and load pointer
// [R5] start or stop after address byte ends write, keeps new pointer
// [R6] read control byte acked, then data sent from current pointer
// [R7] 32-bit registers, word pointer, bytes msb first
// [R8] no response or state change before initialization completes
// [R9] host polls test register with single reads, then ready bit
// [R10] outside full power state ignore all serial activity
// [R11] four bytes per register; nack on fourth leaves pointer unchanged (code steps the pointer on that nack in a burst read)
// [R12] ack on fourth byte increments pointer with wrap and sends next
// [R13] nack on bytes one to three stops sending; start/stop aborts
// [R14] unused register addresses read as zero
// [R15] snapshot whole register at start of every register read
// [R16] read side effect strobed on ack of third byte only
// [R17] nack, start or stop before third ack: no side effect
// [R18] register file defers live events until the side effect strobe
// [R19] ack every write byte, update register after all 32 bits
// [R20] partial word at start or stop is discarded
// [R21] extra bytes write next register; pointer steps after each word (code keeps the pointer after a single-word write)
// [R22] host never writes unused register addresses
// [R23] serial pins pass two-flop synchronizers before edge detection
module isr_target #(
   parameter int PTR_W = isr_pkg::ISR_PTR_W
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // configuration
   input wire logic init_done_in,
   input wire logic full_power_state_in,
   input wire logic addr_override_strap_in,
   input wire logic [6:0] addr_strap_in,
   // serial pins
   input wire logic mgmt_serial_clock_in,
   input wire logic mgmt_serial_data_in,
   output logic mgmt_serial_data_out,
   output logic mgmt_serial_data_oe_out,
   // register file side
   output isr_pkg::isr_req_t req_out,
   input wire logic [31:0] rdata_in,
   input wire logic rd_used_in
);
   import isr_pkg::*;

   // ==========================================================
   // pin synchronizers and condition detection
   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_q_reg, sda_q_reg;
   // [R23] two-flop sampling
   always_ff @(posedge core_clk_in) begin
      scl_sync_reg <= {scl_sync_reg[0], mgmt_serial_clock_in};
      sda_sync_reg <= {sda_sync_reg[0], mgmt_serial_data_in};
      scl_q_reg <= scl_sync_reg[1];
      sda_q_reg <= sda_sync_reg[1];
   end
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   // [R8] gated while not ready
   wire live = init_done_in && full_power_state_in; // [R10] power gating too
   wire scl_rise = live && scl_s && !scl_q_reg;
   wire scl_fall = live && !scl_s && scl_q_reg;
   wire start_c = live && scl_s && scl_q_reg && sda_q_reg && !sda_s;
   wire stop_c = live && scl_s && scl_q_reg && !sda_q_reg && sda_s;

   // [R1] [R2] own address selection
   wire [6:0] own_addr = addr_override_strap_in ? addr_strap_in : ISR_DEF_ADDR;

   // ==========================================================
   // target engine
   isr_state_t state_reg;
   logic [2:0] bit_reg;
   logic [7:0] shift_reg;
   logic [1:0] byte_reg;
   logic [PTR_W-1:0] ptr_reg;
   logic [31:0] wbuf_reg, snap_reg;
   logic rnw_reg, have_ptr_reg, ack_ok_reg;
   // words completed in this write, saturating at 2; a single word must not step the pointer
   logic [1:0] wcnt_reg;
   // set once a register of this read was acked on its fourth byte (burst read)
   logic rburst_reg;
   logic sda_drv_reg;
   isr_req_t req_reg;

   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire [PTR_W-1:0] ptr_inc = ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
   wire [PTR_W-1:0] ptr_inc2 = ptr_reg + {{(PTR_W-2){1'b0}}, 2'h2};
   wire last_bit = (bit_reg == 3'h0);
   // [R7] snapshot byte select, msb first
   wire [7:0] snap_byte = snap_reg[8*(3-byte_reg) +: 8];
   // [R14] unused addresses return zero
   wire [31:0] rd_val = rd_used_in ? rdata_in : 32'h0;

   assign req_out = req_reg;
   assign mgmt_serial_data_out = 1'b0; // open drain: only pulls low
   assign mgmt_serial_data_oe_out = sda_drv_reg;

   // main sequencer, one event per scl edge
   always_ff @(posedge core_clk_in) begin
      req_reg.wr <= 1'b0;
      req_reg.rd_capture <= 1'b0;
      req_reg.rd_commit <= 1'b0;
      if (!rst_n_in) begin
         state_reg <= ISR_IDLE;
         bit_reg <= ISR_BIT_MSB;
         shift_reg <= 8'h00;
         byte_reg <= 2'h0;
         ptr_reg <= ISR_PTR_RST;
         wbuf_reg <= 32'h0;
         snap_reg <= 32'h0;
         rnw_reg <= 1'b0;
         have_ptr_reg <= 1'b0;
         ack_ok_reg <= 1'b0;
         wcnt_reg <= 2'h0;
         rburst_reg <= 1'b0;
         sda_drv_reg <= 1'b0;
         req_reg <= '0;
      end else if (start_c) begin
         // [R5] [R13] [R17] [R20] abort: partial word dropped, pointer kept
         state_reg <= ISR_CTRL;
         bit_reg <= ISR_BIT_MSB;
         sda_drv_reg <= 1'b0;
      end else if (stop_c) begin
         state_reg <= ISR_IDLE;
         sda_drv_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ISR_IDLE: begin
               // [R3] ignore everything until a start
               sda_drv_reg <= 1'b0;
            end
            ISR_CTRL: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_reg <= bit_reg - 3'h1;
                  if (last_bit) begin
                     // [R3] address compare
                     if (rx_byte[7:1] == own_addr) begin
                        state_reg <= ISR_CACK;
                        rnw_reg <= rx_byte[0];
                     end else begin
                        state_reg <= ISR_IDLE;
                     end
                  end
               end
            end
            ISR_CACK: begin
               if (scl_fall && !sda_drv_reg) begin
                  sda_drv_reg <= 1'b1;
               end else if (scl_fall) begin
                  // ack slot over
                  byte_reg <= 2'h0;
                  bit_reg <= ISR_BIT_MSB;
                  have_ptr_reg <= 1'b0;
                  wcnt_reg <= 2'h0;
                  rburst_reg <= 1'b0;
                  if (rnw_reg) begin
                     // [R6] [R15] capture from current pointer
                     state_reg <= ISR_TXB;
                     req_reg.addr <= ptr_reg;
                     req_reg.rd_capture <= 1'b1;
                     snap_reg <= rd_val;
                     sda_drv_reg <= !rd_val[31];
                  end else begin
                     state_reg <= ISR_RXB;
                     sda_drv_reg <= 1'b0;
                  end
               end
            end
            ISR_RXB: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_reg <= bit_reg - 3'h1;
                  if (last_bit) begin
                     state_reg <= ISR_RACK;
                  end
               end
            end
            ISR_RACK: begin
               if (scl_fall && !sda_drv_reg) begin
                  // [R19] ack every byte; [R4] including the pointer byte
                  sda_drv_reg <= 1'b1;
                  if (!have_ptr_reg) begin
                     ptr_reg <= shift_reg[PTR_W-1:0];
                     have_ptr_reg <= 1'b1;
                  end else begin
                     wbuf_reg <= {wbuf_reg[23:0], shift_reg};
                     byte_reg <= byte_reg + 2'h1;
                     // [R19] [R21] commit full word, then step pointer from the second word of a burst on
                     if (byte_reg == ISR_BYTE_LAST) begin
                        req_reg.wr <= 1'b1;
                        req_reg.wdata <= {wbuf_reg[23:0], shift_reg};
                        // single write keeps the pointer; a burst catches up by two
                        if (wcnt_reg == 2'h0) begin
                           req_reg.addr <= ptr_reg;
                           wcnt_reg <= 2'h1;
                        end else if (wcnt_reg == 2'h1) begin
                           req_reg.addr <= ptr_inc;
                           ptr_reg <= ptr_inc2;
                           wcnt_reg <= 2'h2;
                        end else begin
                           req_reg.addr <= ptr_reg;
                           ptr_reg <= ptr_inc;
                        end
                     end
                  end
               end else if (scl_fall) begin
                  sda_drv_reg <= 1'b0;
                  bit_reg <= ISR_BIT_MSB;
                  state_reg <= ISR_RXB;
               end
            end
            ISR_TXB: begin
               if (scl_fall) begin
                  bit_reg <= bit_reg - 3'h1;
                  if (last_bit) begin
                     state_reg <= ISR_TACK;
                     sda_drv_reg <= 1'b0;
                  end else begin
                     sda_drv_reg <= !snap_byte[bit_reg - 3'h1];
                  end
               end
            end
            ISR_TACK: begin
               if (scl_rise) begin
                  ack_ok_reg <= !sda_s;
                  // [R16] side effect only on ack of third byte
                  if (!sda_s && byte_reg == ISR_BYTE_SIDE) begin
                     // [R18] commit strobe releases deferred live events
                     req_reg.rd_commit <= 1'b1;
                  end
                  // [R11] [R12] fourth byte: ack steps; final nack steps only in a burst
                  if (byte_reg == ISR_BYTE_LAST) begin
                     if (!sda_s) begin
                        ptr_reg <= ptr_inc;
                        rburst_reg <= 1'b1;
                     end else if (rburst_reg) begin
                        ptr_reg <= ptr_inc;
                     end
                  end
               end else if (scl_fall) begin
                  bit_reg <= ISR_BIT_MSB;
                  if (!ack_ok_reg) begin
                     // [R13] nack: stop sending
                     state_reg <= ISR_IDLE;
                  end else if (byte_reg == ISR_BYTE_LAST) begin
                     // [R12] [R15] next register, fresh snapshot
                     state_reg <= ISR_TXB;
                     byte_reg <= 2'h0;
                     req_reg.addr <= ptr_reg;
                     req_reg.rd_capture <= 1'b1;
                     snap_reg <= rd_val;
                     sda_drv_reg <= !rd_val[31];
                  end else begin
                     state_reg <= ISR_TXB;
                     byte_reg <= byte_reg + 2'h1;
                     sda_drv_reg <= !snap_reg[8*(2-byte_reg) + 7];
                  end
               end
            end
            default: state_reg <= ISR_IDLE;
         endcase
      end
   end

   // ==========================================================
   // checks
   // [R8] silent before init
   silent_init_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !init_done_in |=> !$rose(sda_drv_reg)) // [R8]
      else $error("target drove data before init");
   // [R10] silent outside full power
   silent_power_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !full_power_state_in && state_reg == ISR_IDLE |=> state_reg == ISR_IDLE) // [R10]
      else $error("state moved outside full power");
   // [R3] mismatch returns idle
   addr_miss_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg == ISR_CTRL && scl_rise && last_bit && !start_c && !stop_c
      && rx_byte[7:1] != own_addr |=> state_reg == ISR_IDLE) // [R3]
      else $error("mismatched address not ignored");
   // [R16] commit only after ack of third byte
   commit_third_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      req_reg.rd_commit |-> byte_reg == ISR_BYTE_SIDE && $past(state_reg) == ISR_TACK) // [R16]
      else $error("read commit at wrong byte");
   // [R19] write strobe only after fourth byte
   write_word_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      req_reg.wr |-> $past(byte_reg) == ISR_BYTE_LAST && $past(state_reg) == ISR_RACK) // [R19]
      else $error("write strobe before full word");
   // [R21] pointer steps after a word of a burst
   write_step_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      req_reg.wr && wcnt_reg == 2'h2
      |-> ptr_reg == req_reg.addr + {{(PTR_W-1){1'b0}}, 1'b1}) // [R21]
      else $error("pointer not stepped after write");
   // [R21] single word keeps pointer
   single_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      req_reg.wr && wcnt_reg == 2'h1 |-> ptr_reg == req_reg.addr) // [R21]
      else $error("pointer moved after single write");
   // [R15] every capture loads snapshot
   snap_load_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      req_reg.rd_capture |-> snap_reg == $past(rd_val)) // [R15]
      else $error("snapshot not taken at capture");
   // [R13] stop releases data line
   stop_release_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      stop_c |=> !sda_drv_reg && state_reg == ISR_IDLE) // [R13]
      else $error("data not released on stop");
endmodule

//--- bench/isr_host.sv
`timescale 1ns/10ps
// ========================================
// host serial master; the clock stands still high between frames
module isr_host (
   // serial lines
   output logic scl_out,
   output logic sda_drv_out,
   input wire logic sda_in
);
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // one clock pulse; data moves only while the clock is low
   task automatic bit_x(input logic v, output logic r);
      #80 sda_drv_out = v;
      #80 scl_out = 1'b1;
      #80 r = sda_in;
      #80 scl_out = 1'b0;
   endtask
   // start or repeated start
   task automatic start();
      #80 sda_drv_out = 1'b1;
      #80 scl_out = 1'b1;
      #160 sda_drv_out = 1'b0;
      #160 scl_out = 1'b0;
   endtask
   task automatic stop();
      #80 sda_drv_out = 1'b0;
      #80 scl_out = 1'b1;
      #160 sda_drv_out = 1'b1;
      #160;
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, ack);
   endtask
   // byte in, then ack or nack
   task automatic rd_byte(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(nack, r);
   endtask
endmodule

//--- bench/isr_target_test.sv
`timescale 1ns/10ps
module isr_target_test;
   import isr_pkg::*;
   logic clk, rst_n, init_ok, pwr_on, ovr, scl, sda_drv, sda, sdo, oe, used, ack;
   logic [6:0] strap, dev;
   logic [31:0] rdata, regs [16];
   logic [7:0] bptr, eptr, cap, b;
   isr_req_t req;
   int err_total, compares, wr_cnt, com_cnt, c;
   // open-drain data wire with pull-up; unused places feed junk to prove zero fill
   assign sda = sda_drv & ~(oe & ~sdo);
   assign used = (bptr < 8'h10);
   assign rdata = used ? regs[bptr[3:0]] : 32'hc35a_96e1;
   isr_host host (.scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda));
   isr_target #(.PTR_W(8)) DUT (.core_clk_in(clk), .rst_n_in(rst_n), .init_done_in(init_ok),
      .full_power_state_in(pwr_on), .addr_override_strap_in(ovr), .addr_strap_in(strap),
      .mgmt_serial_clock_in(scl), .mgmt_serial_data_in(sda), .mgmt_serial_data_out(sdo),
      .mgmt_serial_data_oe_out(oe), .req_out(req), .rdata_in(rdata), .rd_used_in(used));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // register file model driven by the request bundle
   always @(posedge clk) begin
      if (req.wr === 1'b1 && req.addr < 8'h10) regs[req.addr[3:0]] <= req.wdata;
      if (req.wr === 1'b1) wr_cnt++;
      if (req.rd_capture === 1'b1) cap <= req.addr;
      if (req.rd_commit === 1'b1) com_cnt++;
   end
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      return (a < 8'h10) ? regs[a[3:0]] : 32'h0;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic ctrl(input logic rd, input logic exp_ack);
      host.start();
      host.wr_byte({dev, rd}, ack);
      chk(ack, exp_ack);
   endtask
   // pointer byte then nb data bytes; only whole words may land
   task automatic wr_bytes(input logic [7:0] p, input int nb);
      logic [31:0] w, q[$];
      int c0;
      c0 = wr_cnt;
      ctrl(1'b0, 1'b0);
      host.wr_byte(p, ack);
      chk(ack, 1'b0);
      for (int i = 0; i < nb; i++) begin
         w = {w[23:0], 8'($urandom)};
         host.wr_byte(w[7:0], ack);
         chk(ack, 1'b0);
         if (i % 4 == 3) q.push_back(w);
      end
      host.stop();
      chk(wr_cnt - c0, q.size());
      foreach (q[k]) chk(regs[4'(p + k)], q[k]);
      eptr = (nb / 4 > 1) ? p + 8'(nb / 4) : p;
   endtask
   // n registers; rdata moves before the 4th byte to expose a missing snapshot
   task automatic rd_words(input int n);
      logic [31:0] e, w;
      int c0;
      c0 = com_cnt;
      bptr = eptr;
      ctrl(1'b1, 1'b0);
      for (int k = 0; k < n; k++) begin
         e = exp_rd(eptr);
         for (int j = 3; j >= 0; j--) begin
            if (j == 0) bptr = eptr + 8'h01;
            host.rd_byte(j == 0 && k == n - 1, b);
            w[8*j+:8] = b;
            if (j == 3) chk(cap, eptr);
         end
         chk(w, e);
         if (k < n - 1) eptr = eptr + 8'h01;
      end
      host.stop();
      chk(com_cnt - c0, n);
      if (n > 1) eptr = eptr + 8'h01;
   endtask
   initial begin
      #3000000;
      err_total++;
      complete_run();
   end
   initial begin
      c = $urandom(43105);
      {rst_n, init_ok, pwr_on, ovr, strap, dev, bptr} = {4'h6, 7'h00, ISR_DEF_ADDR, 8'h00};
      foreach (regs[i]) regs[i] = $urandom;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      wr_bytes(8'h02, 4);
      rd_words(1);
      rd_words(1);
      wr_bytes(8'h0e, 8);
      rd_words(1);
      wr_bytes(8'hff, 0);
      rd_words(3);
      rd_words(1);
      $display("test 1 done");
      c = com_cnt;
      ctrl(1'b1, 1'b0);
      host.rd_byte(1'b0, b);
      host.rd_byte(1'b1, b);
      host.rd_byte(1'b1, b);
      host.stop();
      chk(b, 8'hff);
      chk(com_cnt - c, 0);
      wr_bytes(8'h05, 6);
      $display("test 2 done");
      dev = ISR_DEF_ADDR ^ 7'h01;
      ctrl(1'b0, 1'b1);
      host.wr_byte(8'h00, ack);
      host.stop();
      chk(ack, 1'b1);
      dev = ISR_DEF_ADDR;
      init_ok = 1'b0;
      ctrl(1'b0, 1'b1);
      host.stop();
      init_ok = 1'b1;
      pwr_on = 1'b0;
      ctrl(1'b0, 1'b1);
      host.stop();
      pwr_on = 1'b1;
      strap = 7'($urandom) | 7'h40;
      ovr = 1'b1;
      ctrl(1'b0, 1'b1);
      host.stop();
      dev = strap;
      wr_bytes(8'h09, 4);
      rd_words(1);
      $display("test 3 done");
      // random traffic; the host keeps writes inside the used places
      repeat (4) begin
         wr_bytes(8'($urandom % 14), 8);
         rd_words(2);
      end
      $display("test 4 done");
      complete_run();
   end
endmodule
